// [inc/mfc_cfg.svh]
// Constants of the metering front-end control block: register map, field
// positions and timing counts. Included by the package; the design files use its macros.
`ifndef MFC_CFG_SVH
`define MFC_CFG_SVH

// Avalon word-address map (byte address is four times the index)
`define MFC_ADDR_W 4
`define MFC_REG_GAIN 4'h0
`define MFC_REG_STATUS 4'h1
`define MFC_REG_RSTATUS 4'h2
`define MFC_REG_MASK 4'h3
`define MFC_REG_SMPSEL 4'h4
`define MFC_REG_SAMPLE 4'h5
`define MFC_REG_RXDATA 4'h6
`define MFC_REG_TXDATA 4'h7

// Gain register fields
`define MFC_GAIN_CUR_LSB 0
`define MFC_GAIN_CUR_MSB 1
`define MFC_GAIN_VOLT_LSB 5
`define MFC_GAIN_VOLT_MSB 6
`define MFC_GAIN_RESET 2'h0

// Status and mask bits
`define MFC_ST_W 3
`define MFC_ST_DROP 0
`define MFC_ST_SAMPLE 1
`define MFC_ST_RXBYTE 2
`define MFC_ST_NOMASK 3'h6

// Converter parameters
`define MFC_NUM_IN 6
`define MFC_SEL_W 3
`define MFC_SAMPLE_W 24
`define MFC_DECIM_LOG2 7
`define MFC_MOD_DIV 12
`define MFC_DIV_W 4
`define MFC_BYTE_W 8
`define MFC_BIT_W 3

// Supply monitor filter: enter and leave times give the hysteresis
`define MFC_CLK_MHZ 50
`define MFC_DROP_ENTER_NS 2000
`define MFC_DROP_LEAVE_NS 4000
`define MFC_DROP_ENTER_CYC ((`MFC_DROP_ENTER_NS * `MFC_CLK_MHZ + 999) / 1000)
`define MFC_DROP_LEAVE_CYC ((`MFC_DROP_LEAVE_NS * `MFC_CLK_MHZ + 999) / 1000)
`define MFC_FILT_W 8

// Pin synchroniser: sclk, select, data in, supply-low comparator
`define MFC_NUM_PINS 4
`define MFC_PIN_SCLK 0
`define MFC_PIN_SEL_N 1
`define MFC_PIN_DIN 2
`define MFC_PIN_LOW 3

`endif

// [inc/mfc_pkg.sv]
// Types shared by the metering front-end control files.
// Assumes mfc_cfg.svh is on the include path.
`include "mfc_cfg.svh"
package mfc_pkg;
  // Gain codes in field order: x1, x2, x4, reserved
  typedef enum logic [1:0] {MFC_GAIN_X1, MFC_GAIN_X2, MFC_GAIN_X4, MFC_GAIN_RSVD} mfc_gain_e;
  typedef logic [`MFC_SAMPLE_W-1:0] mfc_sample_t;
endpackage

// [rtl/mfc_decim.sv]
// Decimation filter for the one-bit modulator streams of all inputs.
// Assumes modulator bits are valid in the cycle mod_strobe_i is high.
`timescale 1ns/10ps
module mfc_decim
  import mfc_pkg::*;
#(
  parameter int NUM_IN = `MFC_NUM_IN,
  parameter int LOG2_OSR = `MFC_DECIM_LOG2
) (
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire logic mod_strobe_i,
  input wire logic [NUM_IN-1:0] mod_bits_i,
  output logic [NUM_IN*`MFC_SAMPLE_W-1:0] samples_o,
  output logic valid_o
);
  localparam int SHIFT = `MFC_SAMPLE_W - 2 - LOG2_OSR;
  logic [LOG2_OSR-1:0] bit_cnt;
  logic last;

  assign last = mod_strobe_i && (&bit_cnt);

  // One shared count of modulator bits closes every channel's word together
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      bit_cnt <= '0;
      valid_o <= 1'b0;
    end else begin
      valid_o <= last;
      if (mod_strobe_i) begin
        bit_cnt <= bit_cnt + 1'b1;
      end
    end
  end

  // Boxcar average per input: +1 per one, -1 per zero, scaled to full word
  for (genvar g = 0; g < NUM_IN; g++) begin : g_chan
    logic signed [LOG2_OSR+1:0] acc;
    logic signed [LOG2_OSR+1:0] next_acc;
    logic signed [`MFC_SAMPLE_W-1:0] wide;
    logic signed [`MFC_SAMPLE_W-1:0] word;
    // One process per channel owns its word; the slice is wired out here
    assign samples_o[g*`MFC_SAMPLE_W +: `MFC_SAMPLE_W] = word;
    assign next_acc = acc + (mod_bits_i[g] ? (LOG2_OSR+2)'(1) : -(LOG2_OSR+2)'(1));
    assign wide = `MFC_SAMPLE_W'(next_acc);
    always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
        acc <= '0;
        word <= '0;
      end else if (mod_strobe_i) begin
        if (last) begin
          // Full scale lands on +/-2^22, signed word
          word <= wide <<< SHIFT;
          acc <= '0;
        end else begin
          acc <= next_acc;
        end
      end
    end
  end
endmodule

// [rtl/mfc_ctrl.sv]
// Metering front-end control: register slave, serial pin handling, supply
// monitor, modulator clock divide and gain selection.
// Assumes an Avalon-MM master on clock_i and a host on the serial pins.
// Behaviour
// - Serial port answers only while select is held low by the host.
// - Serial input bits are captured on falling serial clock edges.
// - Serial output bits change on rising serial clock edges.
// - Serial output is released except while driving read data.
// - Serial shifting is timed only by the host serial clock edges; the code shifts on clock_i once those edges are synchronised.
// - While supply is low the block goes inactive, no energy accumulation.
// - Supply-low indication is filtered with hysteresis against noise.
// - Supply dropout sets the dropout status flag.
// - The dropout flag can never drive the interrupt request.
// - Each channel gain selects one of three values: one, two, four.
// - One gain setting serves all three inputs of a channel.
// - Gain register bits one and zero select current channel gain.
// - Gain register bits six and five select voltage channel gain.
// - Modulator sampling clock is the master clock divided by twelve.
// - Decimation averages the bit stream into signed 24-bit words.
// - Low reset holds converters and all digital logic in reset.
// - Interrupt output is active-low open drain, driven on pending events.
`timescale 1ns/10ps
module mfc_ctrl
  import mfc_pkg::*;
(
  input wire logic clock_i,
  input wire logic rstn_i,
  // Avalon-MM slave
  input wire logic [`MFC_ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Serial pins
  input wire logic serial_sel_n_i,
  input wire logic serial_clk_i,
  input wire logic serial_din_i,
  output logic serial_dout_o,
  output logic serial_dout_oe_o,
  // Interrupt request, open drain
  output logic irq_n_o,
  output logic irq_n_oe_o,
  // Analog front end
  input wire logic supply_low_i,
  input wire logic [`MFC_NUM_IN-1:0] mod_bits_i,
  output logic mod_clk_o,
  output logic mod_strobe_o,
  output logic [1:0] cur_gain_o,
  output logic [1:0] volt_gain_o,
  output logic accumulate_en_o
);
  logic [`MFC_NUM_PINS-1:0] pin_f;
  logic [`MFC_NUM_PINS-1:0] pin_fd;
  logic sclk_rise;
  logic sclk_fall;
  logic sel_fall;
  logic sel_active;
  logic low_f;
  logic [`MFC_DIV_W-1:0] div_cnt;
  logic [`MFC_DIV_W-1:0] next_div;
  logic inactive;
  logic [`MFC_FILT_W-1:0] filt_cnt;
  logic drop_set;
  logic [`MFC_ST_W-1:0] status;
  logic [`MFC_ST_W-1:0] mask;
  logic [`MFC_ST_W-1:0] next_status;
  logic [`MFC_ST_W-1:0] pending;
  logic [`MFC_SEL_W-1:0] smp_sel;
  logic [`MFC_NUM_IN*`MFC_SAMPLE_W-1:0] samples;
  logic smp_valid;
  logic [`MFC_BYTE_W-1:0] rx_shift;
  logic [`MFC_BYTE_W-1:0] rx_data;
  logic [`MFC_BIT_W-1:0] rx_cnt;
  logic rx_event;
  logic [`MFC_BYTE_W-1:0] tx_data;
  logic [`MFC_BYTE_W-1:0] tx_shift;
  logic tx_armed;
  logic wr_take;
  logic rd_take;
  logic [31:0] rd_mux;
  mfc_gain_e wr_cur;
  mfc_gain_e wr_volt;

  // Three-stage synchronisers; a level counts once stages two and three agree
  for (genvar p = 0; p < `MFC_NUM_PINS; p++) begin : g_sync
    logic s1, s2, s3, f, fd;
    assign pin_f[p] = f;
    assign pin_fd[p] = fd;
    always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
        s1 <= (p == `MFC_PIN_SEL_N || p == `MFC_PIN_SCLK);
        s2 <= (p == `MFC_PIN_SEL_N || p == `MFC_PIN_SCLK);
        s3 <= (p == `MFC_PIN_SEL_N || p == `MFC_PIN_SCLK);
        f <= (p == `MFC_PIN_SEL_N || p == `MFC_PIN_SCLK);
        fd <= (p == `MFC_PIN_SEL_N || p == `MFC_PIN_SCLK);
      end else begin
        s1 <= (p == `MFC_PIN_SCLK) ? serial_clk_i :
              (p == `MFC_PIN_SEL_N) ? serial_sel_n_i :
              (p == `MFC_PIN_DIN) ? serial_din_i : supply_low_i;
        s2 <= s1;
        s3 <= s2;
        if (s2 == s3) begin
          f <= s3;
        end
        fd <= f;
      end
    end
  end

  // Serial edges exist only while select is low
  assign sel_active = !pin_f[`MFC_PIN_SEL_N];
  assign sclk_rise = sel_active && pin_f[`MFC_PIN_SCLK] && !pin_fd[`MFC_PIN_SCLK];
  assign sclk_fall = sel_active && !pin_f[`MFC_PIN_SCLK] && pin_fd[`MFC_PIN_SCLK];
  assign sel_fall = sel_active && pin_fd[`MFC_PIN_SEL_N];
  assign low_f = pin_f[`MFC_PIN_LOW];

  // Receive shifter: one bit per falling serial clock edge
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rx_shift <= '0;
      rx_cnt <= '0;
      rx_data <= '0;
      rx_event <= 1'b0;
    end else begin
      rx_event <= 1'b0;
      if (!sel_active) begin
        rx_cnt <= '0; // A released select drops a partial byte
      end else if (sclk_fall) begin
        rx_shift <= {rx_shift[`MFC_BYTE_W-2:0], pin_f[`MFC_PIN_DIN]};
        rx_cnt <= rx_cnt + 1'b1;
        if (&rx_cnt) begin
          rx_data <= {rx_shift[`MFC_BYTE_W-2:0], pin_f[`MFC_PIN_DIN]};
          rx_event <= 1'b1;
        end
      end
    end
  end

  // Transmit shifter: MSB presented at select fall, next bit per rising edge
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tx_shift <= '0;
      serial_dout_o <= 1'b0;
      serial_dout_oe_o <= 1'b0;
    end else if (!sel_active) begin
      serial_dout_oe_o <= 1'b0; // Released whenever not selected
    end else if (sel_fall) begin
      tx_shift <= tx_data;
      serial_dout_o <= tx_data[`MFC_BYTE_W-1];
      serial_dout_oe_o <= tx_armed; // Drives only when read data is loaded
    end else if (sclk_rise) begin
      tx_shift <= {tx_shift[`MFC_BYTE_W-2:0], 1'b0};
      serial_dout_o <= tx_shift[`MFC_BYTE_W-2];
    end
  end

  // Modulator clock: divide by twelve, one bit per period
  assign next_div = (div_cnt == `MFC_DIV_W'(`MFC_MOD_DIV - 1)) ? '0 : div_cnt + 1'b1;
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      div_cnt <= '0;
      mod_clk_o <= 1'b0;
      mod_strobe_o <= 1'b0;
    end else begin
      div_cnt <= next_div;
      mod_clk_o <= (next_div < `MFC_DIV_W'(`MFC_MOD_DIV / 2));
      mod_strobe_o <= (next_div == '0);
    end
  end

  // Averaging of the modulator streams into sample words
  mfc_decim #(
    .NUM_IN(`MFC_NUM_IN),
    .LOG2_OSR(`MFC_DECIM_LOG2)
  ) u_decim (
    .clock_i(clock_i),
    .rstn_i(rstn_i),
    .mod_strobe_i(mod_strobe_o),
    .mod_bits_i(mod_bits_i),
    .samples_o(samples),
    .valid_o(smp_valid)
  );

  // Supply monitor: different enter and leave times form the hysteresis,
  // so a short glitch on the comparator never flips the state
  assign drop_set = !inactive && low_f && (filt_cnt == `MFC_FILT_W'(`MFC_DROP_ENTER_CYC - 1));
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      inactive <= 1'b0;
      filt_cnt <= '0;
    end else if (!inactive) begin
      if (!low_f) begin
        filt_cnt <= '0;
      end else if (drop_set) begin
        inactive <= 1'b1;
        filt_cnt <= '0;
      end else begin
        filt_cnt <= filt_cnt + 1'b1;
      end
    end else begin
      if (low_f) begin
        filt_cnt <= '0;
      end else if (filt_cnt == `MFC_FILT_W'(`MFC_DROP_LEAVE_CYC - 1)) begin
        inactive <= 1'b0;
        filt_cnt <= '0;
      end else begin
        filt_cnt <= filt_cnt + 1'b1;
      end
    end
  end

  // Accumulation is stopped while the supply is low
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      accumulate_en_o <= 1'b0; // Held off through reset
    end else begin
      accumulate_en_o <= !inactive;
    end
  end

  // Avalon handshake: one wait cycle, then waitrequest low for one cycle
  assign wr_take = avs_write_i && !avs_waitrequest_o;
  assign rd_take = avs_read_i && !avs_waitrequest_o;
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o <= '0;
    end else if ((avs_read_i || avs_write_i) && avs_waitrequest_o) begin
      avs_waitrequest_o <= 1'b0;
      avs_readdata_o <= avs_read_i ? rd_mux : '0;
    end else begin
      avs_waitrequest_o <= 1'b1;
    end
  end

  // Read mux; unmapped words read as zero
  always_comb begin
    rd_mux = '0;
    unique case (avs_address_i)
      `MFC_REG_GAIN: begin
        rd_mux[`MFC_GAIN_CUR_MSB:`MFC_GAIN_CUR_LSB] = cur_gain_o;
        rd_mux[`MFC_GAIN_VOLT_MSB:`MFC_GAIN_VOLT_LSB] = volt_gain_o;
      end
      `MFC_REG_STATUS, `MFC_REG_RSTATUS: rd_mux[`MFC_ST_W-1:0] = status;
      `MFC_REG_MASK: rd_mux[`MFC_ST_W-1:0] = mask;
      `MFC_REG_SMPSEL: rd_mux[`MFC_SEL_W-1:0] = smp_sel;
      `MFC_REG_SAMPLE: begin
        if (smp_sel < `MFC_SEL_W'(`MFC_NUM_IN)) begin
          rd_mux[`MFC_SAMPLE_W-1:0] = samples[smp_sel*`MFC_SAMPLE_W +: `MFC_SAMPLE_W];
        end
      end
      `MFC_REG_RXDATA: rd_mux[`MFC_BYTE_W-1:0] = rx_data;
      `MFC_REG_TXDATA: rd_mux[`MFC_BYTE_W-1:0] = tx_data;
      default: rd_mux = '0;
    endcase
  end

  // Gain writes: a reserved code leaves that field unchanged
  assign wr_cur = mfc_gain_e'(avs_writedata_i[`MFC_GAIN_CUR_MSB:`MFC_GAIN_CUR_LSB]);
  assign wr_volt = mfc_gain_e'(avs_writedata_i[`MFC_GAIN_VOLT_MSB:`MFC_GAIN_VOLT_LSB]);
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cur_gain_o <= `MFC_GAIN_RESET;
      volt_gain_o <= `MFC_GAIN_RESET;
    end else if (wr_take && avs_address_i == `MFC_REG_GAIN) begin
      if (wr_cur != MFC_GAIN_RSVD) begin
        cur_gain_o <= wr_cur; // One field for all three current inputs
      end
      if (wr_volt != MFC_GAIN_RSVD) begin
        volt_gain_o <= wr_volt; // One field for all three voltage inputs
      end
    end
  end

  // Other writable registers; writing the transmit byte arms the output
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mask <= '0;
      smp_sel <= '0;
      tx_data <= '0;
      tx_armed <= 1'b0;
    end else begin
      if (wr_take && avs_address_i == `MFC_REG_MASK) begin
        mask <= avs_writedata_i[`MFC_ST_W-1:0];
      end
      if (wr_take && avs_address_i == `MFC_REG_SMPSEL) begin
        smp_sel <= avs_writedata_i[`MFC_SEL_W-1:0];
      end
      if (wr_take && avs_address_i == `MFC_REG_TXDATA) begin
        tx_data <= avs_writedata_i[`MFC_BYTE_W-1:0];
        tx_armed <= 1'b1;
      end else if (sel_fall) begin
        tx_armed <= 1'b0; // One armed byte per selection
      end
    end
  end

  // Sticky status; a read of the clearing alias clears only the bits it
  // returned, and a new event in the same cycle still wins
  always_comb begin
    next_status = status;
    if (rd_take && avs_address_i == `MFC_REG_RSTATUS) begin
      next_status = status & ~avs_readdata_o[`MFC_ST_W-1:0];
    end
    next_status[`MFC_ST_DROP] = next_status[`MFC_ST_DROP] | drop_set;
    next_status[`MFC_ST_SAMPLE] = next_status[`MFC_ST_SAMPLE] | smp_valid;
    next_status[`MFC_ST_RXBYTE] = next_status[`MFC_ST_RXBYTE] | rx_event;
  end
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      status <= '0;
    end else begin
      status <= next_status;
    end
  end

  // Interrupt: dropout bit is forced out of the mask
  assign pending = status & mask & `MFC_ST_NOMASK;
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      irq_n_o <= 1'b0;
      irq_n_oe_o <= 1'b0;
    end else begin
      irq_n_o <= 1'b0;
      irq_n_oe_o <= |pending;
    end
  end

  default clocking @(posedge clock_i); endclocking
  default disable iff (!rstn_i);
  gain_code_legal_a:
    assert property (cur_gain_o != 2'h3 && volt_gain_o != 2'h3)
    else $error("reserved gain code applied");
  cur_gain_write_a:
    assert property (wr_take && avs_address_i == `MFC_REG_GAIN
                     && avs_writedata_i[1:0] != 2'h3 |=> cur_gain_o == $past(avs_writedata_i[1:0]))
    else $error("current gain not taken from bits 1:0");
  volt_gain_write_a:
    assert property (wr_take && avs_address_i == `MFC_REG_GAIN
                     && avs_writedata_i[6:5] != 2'h3 |=> volt_gain_o == $past(avs_writedata_i[6:5]))
    else $error("voltage gain not taken from bits 6:5");
  mod_divide_a:
    assert property (mod_strobe_o |=> !mod_strobe_o [*8] ##1 !mod_strobe_o [*3] ##1 mod_strobe_o)
    else $error("modulator strobe period is not twelve");
  accum_stop_a:
    assert property (inactive |=> !accumulate_en_o)
    else $error("accumulation while supply low");
  supply_filter_a:
    assert property ($rose(inactive) |-> $past(low_f, `MFC_DROP_ENTER_CYC))
    else $error("inactive state entered without filtered low supply");
  drop_flag_a:
    assert property ($rose(inactive) |-> status[`MFC_ST_DROP])
    else $error("dropout flag not set on supply drop");
  irq_follow_a:
    assert property (irq_n_oe_o == $past(|(status & mask & `MFC_ST_NOMASK)) && !irq_n_o)
    else $error("interrupt output wrong for pending events");
  dout_release_a:
    assert property (!sel_active |=> !serial_dout_oe_o)
    else $error("serial output driven while deselected");
  dout_edge_a:
    assert property (serial_dout_oe_o && $past(serial_dout_oe_o) && $changed(serial_dout_o)
                     |-> $past(sclk_rise))
    else $error("serial output changed off a rising serial clock edge");
  rx_edge_a:
    assert property (rx_event |-> $past(sclk_fall))
    else $error("byte completed without a falling serial clock edge");
endmodule

// [verification/mfc_host_model.sv]
// Host microcontroller model: serial bus master for the metering front end.
// Assumes tasks are called just after a rising edge of clock_i.
`timescale 1ns/10ps
module mfc_host_model (
  input wire logic clock_i,
  output logic sel_n_o,
  output logic sclk_o,
  output logic din_o,
  input wire logic dout_i,
  input wire logic dout_oe_i
);
  logic last_q;
  logic line;
  // Idle pins; the serial clock stands high outside frames
  initial begin
    sel_n_o = 1'b1;
    sclk_o = 1'b1;
    din_o = 1'b0;
    last_q = 1'b0;
  end
  // A released line shows the inverse of the last driven bit, never a stale copy
  always @(posedge clock_i) begin
    if (dout_oe_i) begin
      last_q <= dout_i;
    end
  end
  assign line = dout_oe_i ? dout_i : ~last_q;
  // One byte each way, MSB first; dout follows a pin edge five clocks late,
  // so the sample waits six clocks after each rising serial clock
  task xfer(input logic [7:0] tx, input logic use_sel, output logic [7:0] rx,
            output logic saw_oe);
    int i;
    saw_oe = 1'b0;
    rx = 8'h00;
    sel_n_o <= ~use_sel;
    repeat (6) @(posedge clock_i);
    for (i = 7; i >= 0; i--) begin
      din_o <= tx[i];
      repeat (6) @(posedge clock_i);
      rx[i] = line;
      saw_oe = saw_oe | dout_oe_i;
      sclk_o <= 1'b0;
      repeat (5) @(posedge clock_i);
      sclk_o <= 1'b1;
    end
    repeat (6) @(posedge clock_i);
    sel_n_o <= 1'b1;
    din_o <= ~din_o;
    repeat (8) @(posedge clock_i);
  endtask
endmodule

// [verification/testbench.sv]
// Self-checking bench for mfc_ctrl: Avalon register tasks, host serial model,
// supply comparator and modulator bits driven from here.
`timescale 1ns/10ps
module testbench
  import mfc_pkg::*;
;
  logic clock_i, rstn_i, avs_read_i, avs_write_i, avs_waitrequest_o;
  logic [3:0] avs_address_i;
  logic [31:0] avs_writedata_i, avs_readdata_o, q;
  logic sel_n, sclk, din, serial_dout_o, serial_dout_oe_o, irq_n_o, irq_n_oe_o, irq_line;
  logic supply_low_i, mod_clk_o, mod_strobe_o, accumulate_en_o, saw;
  logic [5:0] mod_bits_i;
  logic [1:0] cur_gain_o, volt_gain_o;
  logic [7:0] rx;
  int num_errors = 0;
  int cmp_count = 0;
  // Open-drain interrupt wire with its pull-up
  assign irq_line = irq_n_oe_o ? irq_n_o : 1'b1;
  mfc_ctrl DUT (.clock_i(clock_i), .rstn_i(rstn_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .serial_sel_n_i(sel_n), .serial_clk_i(sclk), .serial_din_i(din),
    .serial_dout_o(serial_dout_o), .serial_dout_oe_o(serial_dout_oe_o), .irq_n_o(irq_n_o),
    .irq_n_oe_o(irq_n_oe_o), .supply_low_i(supply_low_i), .mod_bits_i(mod_bits_i),
    .mod_clk_o(mod_clk_o), .mod_strobe_o(mod_strobe_o), .cur_gain_o(cur_gain_o),
    .volt_gain_o(volt_gain_o), .accumulate_en_o(accumulate_en_o));
  mfc_host_model host (.clock_i(clock_i), .sel_n_o(sel_n), .sclk_o(sclk), .din_o(din),
    .dout_i(serial_dout_o), .dout_oe_i(serial_dout_oe_o));
  // 50 MHz system clock
  initial begin
    clock_i = 1'b0;
    forever #10 clock_i = ~clock_i;
  end
  task give_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge clock_i);
  endtask
  // Bus cycle held until waitrequest is sampled low at a rising edge
  task av(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= wr;
    avs_read_i <= ~wr;
    @(posedge clock_i);
    while (avs_waitrequest_o !== 1'b0) begin
      n++;
      if (n > 50) begin
        num_errors++;
        give_verdict();
      end
      @(posedge clock_i);
    end
    q = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
    @(posedge clock_i);
  endtask
  // Bounded wait for the filtered accumulate enable to reach a level
  task wait_acc(input logic lvl);
    int n;
    n = 0;
    while (accumulate_en_o !== lvl && n < 20) begin
      tick(1);
      n++;
    end
    chk(n < 20, 1'b1);
    if (n >= 20) begin
      give_verdict();
    end
  endtask
  task t_gain;
    int i;
    for (i = 0; i < 3; i++) begin
      av(1'b1, `MFC_REG_GAIN, ((2 - i) << 5) | i);
      tick(1);
      chk(cur_gain_o, i);
      chk(volt_gain_o, 2 - i);
      av(1'b0, `MFC_REG_GAIN, 32'h0);
      chk(q, ((2 - i) << 5) | i);
    end
    // Reserved code on one field only: the other field still moves
    av(1'b1, `MFC_REG_GAIN, 32'h0000_0023);
    tick(1);
    chk(cur_gain_o, 2'h2);
    chk(volt_gain_o, 2'h1);
    av(1'b1, 4'h9, 32'h0000_0000);
    av(1'b0, 4'h8, 32'h0);
    chk(q, 32'h0);
    chk(volt_gain_o, 2'h1);
  endtask
  task t_modclk;
    int c, hi;
    c = 0;
    hi = 0;
    while (mod_strobe_o !== 1'b1 && c < 30) begin
      tick(1);
      c++;
    end
    if (c >= 30) begin
      num_errors++;
      give_verdict();
    end
    c = 0;
    do begin
      tick(1);
      c++;
      hi += (mod_clk_o === 1'b1);
    end while (mod_strobe_o !== 1'b1 && c < 30);
    chk(c, 12);
    chk(hi, 6);
    if (c >= 30) begin
      give_verdict();
    end
  endtask
  task t_supply;
    av(1'b1, `MFC_REG_MASK, 32'h1);
    av(1'b0, `MFC_REG_RSTATUS, 32'h0);
    supply_low_i <= 1'b1;
    tick(60);
    supply_low_i <= 1'b0;
    tick(150);
    chk(accumulate_en_o, 1'b1);
    supply_low_i <= 1'b1;
    tick(95);
    chk(accumulate_en_o, 1'b1);
    wait_acc(1'b0);
    chk(irq_line, 1'b1);
    av(1'b0, `MFC_REG_STATUS, 32'h0);
    chk(q[0], 1'b1);
    supply_low_i <= 1'b0;
    tick(190);
    chk(accumulate_en_o, 1'b0);
    wait_acc(1'b1);
    av(1'b0, `MFC_REG_RSTATUS, 32'h0);
    av(1'b0, `MFC_REG_STATUS, 32'h0);
    chk(q[0], 1'b0);
  endtask
  task t_serial;
    av(1'b1, `MFC_REG_TXDATA, 32'hA5);
    av(1'b1, `MFC_REG_MASK, 32'h4);
    av(1'b0, `MFC_REG_RSTATUS, 32'h0);
    chk(serial_dout_oe_o, 1'b0);
    host.xfer(8'h3C, 1'b1, rx, saw);
    chk(rx, 8'hA5);
    chk(saw, 1'b1);
    chk(serial_dout_oe_o, 1'b0);
    chk(irq_line, 1'b0);
    av(1'b0, `MFC_REG_RXDATA, 32'h0);
    chk(q, 32'h3C);
    av(1'b0, `MFC_REG_RSTATUS, 32'h0);
    tick(2);
    chk(irq_line, 1'b1);
    // Not armed: the line must stay released for the whole frame
    host.xfer(8'hC3, 1'b1, rx, saw);
    chk(saw, 1'b0);
    host.xfer(8'h5A, 1'b0, rx, saw);
    chk(saw, 1'b0);
    av(1'b0, `MFC_REG_RXDATA, 32'h0);
    chk(q, 32'hC3);
  endtask
  // Two full 128-bit averaging blocks per level so one is wholly at the new level
  task t_sample;
    av(1'b1, `MFC_REG_SMPSEL, 32'h5);
    mod_bits_i <= 6'h3F;
    tick(3200);
    av(1'b0, `MFC_REG_SAMPLE, 32'h0);
    chk(q[23], 1'b0);
    chk(q, 32'h0040_0000);
    mod_bits_i <= 6'h00;
    tick(3200);
    av(1'b0, `MFC_REG_SAMPLE, 32'h0);
    chk(q[23], 1'b1);
    chk(q, 32'h00C0_0000);
    av(1'b0, `MFC_REG_STATUS, 32'h0);
    chk(q[1], 1'b1);
  endtask
  initial begin
    rstn_i = 1'b0;
    avs_address_i = 4'h0;
    avs_read_i = 1'b0;
    avs_write_i = 1'b0;
    avs_writedata_i = 32'h0;
    supply_low_i = 1'b0;
    mod_bits_i = 6'h15;
    tick(8);
    chk(avs_waitrequest_o, 1'b1);
    chk({serial_dout_oe_o, irq_n_oe_o, accumulate_en_o, mod_strobe_o}, 4'h0);
    chk({cur_gain_o, volt_gain_o}, 4'h0);
    rstn_i <= 1'b1;
    tick(2);
    chk(accumulate_en_o, 1'b1);
    t_gain();
    t_modclk();
    t_supply();
    t_serial();
    t_sample();
    give_verdict();
  end
endmodule
